// ---- dv/iad_decoder_test.sv ----
/*
 * Self-checking bench of the indirect address decoder, one task per scenario.
 * Assumes the memory model answers one cycle after each strobe.
 */
`default_nettype none

// ============================================================
// bench
module iad_decoder_test
	import iad_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, valid = 1'b0, wr = 1'b0, dm_en, dm_we, pm_en;
	logic busy, done, extra;
	logic [7:0] hi = 8'h00, lo = 8'h00, wdata = 8'h00, rdata, dm_wd, dm_rd, rd;
	logic [11:0] dm_addr, last_addr;
	logic [14:0] pm_addr, last_paddr;
	logic [13:0] pm_rd;
	int n_mismatch = 0, total_checks = 0, lat, nd, np, ex, nb;

	initial forever #4 clk = ~clk;

	iad_decoder i_dut (.i_ref_clk(clk), .i_rst(rst), .i_acc_valid(valid),
		.i_acc_write(wr), .i_pointer_high_byte(hi), .i_pointer_low_byte(lo),
		.i_acc_wdata(wdata), .o_busy(busy), .o_done(done), .o_extra_cycle(extra),
		.o_rdata(rdata), .o_dmem_en(dm_en), .o_dmem_we(dm_we), .o_dmem_addr(dm_addr),
		.o_dmem_wdata(dm_wd), .i_dmem_rdata(dm_rd), .o_pmem_en(pm_en),
		.o_pmem_addr(pm_addr), .i_pmem_rdata(pm_rd));

	iad_mem_model i_mem (.i_clk(clk), .i_dmem_en(dm_en), .i_dmem_we(dm_we),
		.i_dmem_addr(dm_addr), .i_dmem_wdata(dm_wd), .o_dmem_rdata(dm_rd),
		.i_pmem_en(pm_en), .i_pmem_addr(pm_addr), .o_pmem_rdata(pm_rd));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// one access; counts strobes and edges up to done
	task automatic acc(input logic w, input logic [15:0] p, input logic [7:0] d);
		@(posedge clk);
		valid <= 1'b1;
		wr <= w;
		{hi, lo} <= p;
		wdata <= d;
		@(posedge clk);
		valid <= 1'b0;
		{lat, nd, np, ex, nb} = {32'd1, 32'd0, 32'd0, 32'd0, 32'd0};
		// stale addresses from the previous access must not satisfy a check
		last_addr = 'x;
		last_paddr = 'x;
		repeat (20)
		begin
			#1;
			if (busy === 1'b1)
				nb++;
			if (dm_en === 1'b1)
			begin
				nd++;
				last_addr = dm_addr;
			end
			if (pm_en === 1'b1)
			begin
				np++;
				last_paddr = pm_addr;
			end
			if (extra === 1'b1)
				ex++;
			if (done === 1'b1)
			begin
				rd = rdata;
				return;
			end
			@(posedge clk);
			lat++;
		end
		n_mismatch++;
		$display("BAD done_timeout expected 1 seen 0");
		report_and_stop();
	endtask

	task automatic t_data();
		logic [15:0] ps[2] = '{16'h0123, 16'h0fff};
		foreach (ps[i])
		begin
			acc(1'b1, ps[i], ps[i][7:0] ^ 8'h5a);
			chk("wr_addr", last_addr, ps[i][11:0]);
			chk("wr_lat", lat, IAD_LAT_DATA);
			chk("busy_cycles", nb, IAD_LAT_DATA - 1);
			acc(1'b0, ps[i], 8'h00);
			chk("rd_data", rd, ps[i][7:0] ^ 8'h5a);
		end
		$display("test data done");
	endtask

	task automatic t_window();
		logic [15:0] ps[4] = '{16'h0000, 16'h0001, 16'h0f80, 16'h0f81};
		foreach (ps[i])
		begin
			acc(1'b1, ps[i], 8'hff);
			chk("win_wr_strobe", nd, 0);
			acc(1'b0, ps[i], 8'h00);
			chk("win_rd", {rd, nd[7:0]}, 0);
		end
		$display("test window done");
	endtask

	task automatic t_linear();
		logic [15:0] ps[4] = '{16'h2000, 16'h204f, 16'h2050, 16'h29af};
		logic [11:0] e;
		foreach (ps[i])
		begin
			e = 12'((ps[i] - 16'h2000) / 80 * 128 + 32 + (ps[i] - 16'h2000) % 80);
			acc(1'b1, ps[i], 8'(i + 8'h11));
			chk("lin_addr", last_addr, e);
			chk("lin_common", last_addr[6:0] >= 7'h70, 0);
			acc(1'b0, {4'h0, e}, 8'h00);
			chk("lin_abs_rd", rd, i + 8'h11);
		end
		$display("test linear done");
	endtask

	task automatic t_unimpl();
		logic [15:0] ps[4] = '{16'h1000, 16'h1fff, 16'h29b0, 16'h7fff};
		foreach (ps[i])
		begin
			acc(1'b1, ps[i], 8'hff);
			chk("un_wr_strobe", nd + np, 0);
			acc(1'b0, ps[i], 8'h00);
			chk("un_rd", rd, 0);
		end
		$display("test unimplemented done");
	endtask

	task automatic t_prog();
		logic [15:0] ps[2] = '{16'h8005, 16'hffff};
		foreach (ps[i])
		begin
			acc(1'b0, ps[i], 8'h00);
			chk("pm_addr", {np[7:0], last_paddr}, {8'h01, ps[i][14:0]});
			chk("pm_rd", rd, ps[i][7:0] ^ 8'hc3);
			chk("pm_lat", {lat[7:0], ex[7:0]}, 16'h0401);
			chk("pm_busy", nb, IAD_LAT_PROG - 1);
			acc(1'b1, ps[i], 8'h77);
			chk("pm_wr_strobe", nd + np, 0);
			chk("pm_wr_lat", lat, IAD_LAT_PROG);
		end
		$display("test program done");
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("reset_idle", {busy, done, extra, dm_en, pm_en}, 0);
		t_data();
		t_window();
		t_linear();
		t_unimpl();
		t_prog();
		report_and_stop();
	end
endmodule
`default_nettype wire

// ---- dv/iad_mem_model.sv ----
/*
 * Memory partner of the indirect address decoder: byte-wide data memory and
 * read-only program memory, each answering one clock after its enable.
 * Assumes the decoder strobes each memory for one cycle per access.
 */
`default_nettype none

// ============================================================
// memory model
module iad_mem_model
	import iad_pkg::*;
(
	// clock
	input wire logic i_clk,
	// data memory
	input wire logic i_dmem_en,
	input wire logic i_dmem_we,
	input wire logic [IAD_DADDR_W-1:0] i_dmem_addr,
	input wire logic [IAD_DATA_W-1:0] i_dmem_wdata,
	output logic [IAD_DATA_W-1:0] o_dmem_rdata,
	// program memory
	input wire logic i_pmem_en,
	input wire logic [IAD_PADDR_W-1:0] i_pmem_addr,
	output logic [IAD_PWORD_W-1:0] o_pmem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [4096];
	logic [7:0] dq = 8'h00;
	logic [13:0] pq = 14'h0000;
	assign o_dmem_rdata = dq;
	assign o_pmem_rdata = pq;
	// outside the answer cycle the data flips, so a late sample shows up
	always @(posedge i_clk)
	begin
		if (i_dmem_en && i_dmem_we)
			mem[i_dmem_addr] <= i_dmem_wdata;
		dq <= (i_dmem_en && !i_dmem_we) ? mem[i_dmem_addr] : ~dq;
		pq <= i_pmem_en ? {i_pmem_addr[13:8], i_pmem_addr[7:0] ^ 8'hc3} : ~pq;
	end
endmodule
`default_nettype wire

// ---- rtl/iad_decoder.sv ----
/*
 * Indirect address decoder: routes one indirect-window access per request to
 * data memory (absolute or linear view), program memory, or nowhere.
 * Assumes synchronous memories that return read data one clock after the
 * enable is sampled, and a core that holds off new requests while busy.
 */
`default_nettype none

module iad_decoder
	import iad_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// core request
	input wire logic i_acc_valid,
	input wire logic i_acc_write,
	input wire logic [7:0] i_pointer_high_byte,
	input wire logic [7:0] i_pointer_low_byte,
	input wire logic [IAD_DATA_W-1:0] i_acc_wdata,
	// core answer
	output logic o_busy,
	output logic o_done,
	output logic o_extra_cycle,
	output logic [IAD_DATA_W-1:0] o_rdata,
	// data memory
	output logic o_dmem_en,
	output logic o_dmem_we,
	output logic [IAD_DADDR_W-1:0] o_dmem_addr,
	output logic [IAD_DATA_W-1:0] o_dmem_wdata,
	input wire logic [IAD_DATA_W-1:0] i_dmem_rdata,
	// program memory, read only
	output logic o_pmem_en,
	output logic [IAD_PADDR_W-1:0] o_pmem_addr,
	input wire logic [IAD_PWORD_W-1:0] i_pmem_rdata
);
	// ============================================================
	// decode helpers
	function automatic logic is_window(input logic [IAD_PTR_W-1:0] ptr);
		logic [IAD_OFS_W-1:0] ofs;
		ofs = ptr[IAD_OFS_W-1:0];
		is_window = (ptr <= IAD_TRAD_LAST)
			&& ((ofs == IAD_WIN_OFS0) || (ofs == IAD_WIN_OFS1));
	endfunction

	function automatic iad_region_t region_of(input logic [IAD_PTR_W-1:0] ptr);
		if (ptr[IAD_PROG_BIT])
			region_of = IAD_RG_PROG;
		else if (is_window(ptr))
			region_of = IAD_RG_NONE;
		else if (ptr <= IAD_TRAD_LAST)
			region_of = IAD_RG_DATA;
		else if ((ptr >= IAD_LIN_BASE) && (ptr <= IAD_LIN_LAST))
			region_of = IAD_RG_LIN;
		else
			region_of = IAD_RG_NONE;
	endfunction

	// ============================================================
	// request decode
	logic [IAD_PTR_W-1:0] req_ptr;
	logic accept;
	iad_region_t req_region;
	logic [IAD_DADDR_W-1:0] lin_addr;

	assign req_ptr = {i_pointer_high_byte, i_pointer_low_byte};

	iad_linear_map u_linear_map (
		.i_ptr(req_ptr),
		.o_addr(lin_addr)
	);

	// ============================================================
	// state
	iad_state_t state_ff, nxt_state;
	iad_region_t region_ff, nxt_region;
	logic write_ff, nxt_write;
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic extra_ff, nxt_extra;
	logic [IAD_DATA_W-1:0] rdata_ff, nxt_rdata;
	logic dmem_en_ff, nxt_dmem_en;
	logic dmem_we_ff, nxt_dmem_we;
	logic [IAD_DADDR_W-1:0] dmem_addr_ff, nxt_dmem_addr;
	logic [IAD_DATA_W-1:0] dmem_wdata_ff, nxt_dmem_wdata;
	logic pmem_en_ff, nxt_pmem_en;
	logic [IAD_PADDR_W-1:0] pmem_addr_ff, nxt_pmem_addr;

	assign accept = i_acc_valid && (state_ff == IAD_ST_IDLE);
	assign req_region = region_of(req_ptr);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_region = region_ff;
		nxt_write = write_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_extra = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_dmem_en = 1'b0;
		nxt_dmem_we = 1'b0;
		nxt_dmem_addr = dmem_addr_ff;
		nxt_dmem_wdata = dmem_wdata_ff;
		nxt_pmem_en = 1'b0;
		nxt_pmem_addr = pmem_addr_ff;
		case (state_ff)
			IAD_ST_IDLE:
			begin
				if (accept)
				begin
					nxt_state = IAD_ST_ISSUE;
					nxt_busy = 1'b1;
					nxt_region = req_region;
					nxt_write = i_acc_write;
					nxt_dmem_wdata = i_acc_wdata;
					// the window never reaches memory itself; it reads zero and writes are dropped
					if (req_region == IAD_RG_DATA)
					begin
						nxt_dmem_en = 1'b1;
						nxt_dmem_we = i_acc_write;
						nxt_dmem_addr = req_ptr[IAD_DADDR_W-1:0];
					end
					else if (req_region == IAD_RG_LIN)
					begin
						nxt_dmem_en = 1'b1;
						nxt_dmem_we = i_acc_write;
						nxt_dmem_addr = lin_addr;
					end
					else if (req_region == IAD_RG_PROG)
					begin
						nxt_pmem_en = !i_acc_write;
						nxt_pmem_addr = req_ptr[IAD_PADDR_W-1:0];
					end
				end
			end
			IAD_ST_ISSUE:
				nxt_state = IAD_ST_CAPT;
			IAD_ST_CAPT:
			begin
				if (write_ff || (region_ff == IAD_RG_NONE))
					nxt_rdata = IAD_RD_ZERO;
				else if (region_ff == IAD_RG_PROG)
					nxt_rdata = i_pmem_rdata[IAD_DATA_W-1:0];
				else
					nxt_rdata = i_dmem_rdata;
				if (region_ff == IAD_RG_PROG)
				begin
					// program memory stretches the instruction by one cycle
					nxt_state = IAD_ST_EXTRA;
					nxt_extra = 1'b1;
				end
				else
				begin
					nxt_state = IAD_ST_IDLE;
					nxt_done = 1'b1;
					nxt_busy = 1'b0;
				end
			end
			IAD_ST_EXTRA:
			begin
				nxt_state = IAD_ST_IDLE;
				nxt_done = 1'b1;
				nxt_busy = 1'b0;
			end
			default:
			begin
				nxt_state = IAD_ST_IDLE;
				nxt_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			state_ff <= IAD_ST_IDLE;
			region_ff <= IAD_RG_NONE;
			write_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			extra_ff <= 1'b0;
			rdata_ff <= IAD_RD_ZERO;
			dmem_en_ff <= 1'b0;
			dmem_we_ff <= 1'b0;
			dmem_addr_ff <= '0;
			dmem_wdata_ff <= '0;
			pmem_en_ff <= 1'b0;
			pmem_addr_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			region_ff <= nxt_region;
			write_ff <= nxt_write;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			extra_ff <= nxt_extra;
			rdata_ff <= nxt_rdata;
			dmem_en_ff <= nxt_dmem_en;
			dmem_we_ff <= nxt_dmem_we;
			dmem_addr_ff <= nxt_dmem_addr;
			dmem_wdata_ff <= nxt_dmem_wdata;
			pmem_en_ff <= nxt_pmem_en;
			pmem_addr_ff <= nxt_pmem_addr;
		end
	end

	assign o_busy = busy_ff;
	assign o_done = done_ff;
	assign o_extra_cycle = extra_ff;
	assign o_rdata = rdata_ff;
	assign o_dmem_en = dmem_en_ff;
	assign o_dmem_we = dmem_we_ff;
	assign o_dmem_addr = dmem_addr_ff;
	assign o_dmem_wdata = dmem_wdata_ff;
	assign o_pmem_en = pmem_en_ff;
	assign o_pmem_addr = pmem_addr_ff;

	// ============================================================
	// checks
	AST_DATA_ROUTE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		accept && (req_region == IAD_RG_DATA) |=> o_dmem_en
			&& (o_dmem_addr == $past(req_ptr[IAD_DADDR_W-1:0])))
		else $error("traditional pointer not passed to data memory");

	AST_WINDOW_SUPPRESS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		accept && is_window(req_ptr) |=> !o_dmem_en && !o_pmem_en
			##2 o_done && (o_rdata == 8'h00))
		else $error("window self access reached memory or read nonzero");

	AST_LIN_IN_BANK: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_dmem_en && (region_ff == IAD_RG_LIN)
			|-> (o_dmem_addr[IAD_OFS_W-1:0] >= IAD_BANK_RAM_START)
			&& (o_dmem_addr[IAD_OFS_W-1:0] <= IAD_BANK_RAM_LAST))
		else $error("linear access outside the banked ram");

	AST_LIN_WRAP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		accept && (req_region == IAD_RG_LIN) && (req_ptr == 16'h2050)
			|=> o_dmem_addr == 12'h0a0)
		else $error("linear region does not continue into next bank");

	AST_UNIMP_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		accept && (req_region == IAD_RG_NONE) && !i_acc_write
			|=> !o_dmem_en ##2 o_done && (o_rdata == 8'h00))
		else $error("unimplemented read not zero");

	AST_PROG_NO_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		accept && req_ptr[IAD_PROG_BIT] && i_acc_write |=> !o_pmem_en && !o_dmem_en)
		else $error("program memory write not dropped");

	AST_PROG_ADDR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		accept && req_ptr[IAD_PROG_BIT] && !i_acc_write
			|=> o_pmem_en && (o_pmem_addr == $past(req_ptr[14:0])))
		else $error("program address not taken from low pointer bits");

	AST_PROG_LOW_BYTE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_ff == IAD_ST_CAPT) && (region_ff == IAD_RG_PROG) && !write_ff
			|=> o_rdata == $past(i_pmem_rdata[7:0]))
		else $error("program read not low byte");

	AST_PROG_EXTRA: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		accept && req_ptr[IAD_PROG_BIT] |=> !o_done [*3] ##1 o_done)
		else $error("program access not one cycle longer");

	AST_DATA_LAT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		accept && !req_ptr[IAD_PROG_BIT] |=> !o_done [*2] ##1 o_done && !o_extra_cycle)
		else $error("data access latency wrong");
endmodule

`default_nettype wire

// ---- rtl/iad_linear_map.sv ----
/*
 * Constants package of the indirect address decoder, and the linear-region
 * mapper that turns a linear pointer into an absolute data-memory address.
 * Assumes a single core instruction clock and pointers already range-checked
 * by the caller before the mapped address is used.
 */
// Notes on behaviour
// - window access goes to the pointed location
// - pointer at window: read 0, no write
// - pointer is high byte joined low byte
// - 0x000-0xfff map onto absolute data addresses
// - 0x2000-0x29af map onto banked 80-byte RAM
// - unimplemented locations read as 0x00
// - linear addresses run on into next bank
// - common memory never appears in linear region
// - pointer msb set selects program memory
// - program read returns low eight bits
// - writes to program memory are dropped
// - program access costs one extra cycle
`default_nettype none

// ============================================================
// package
package iad_pkg;
	localparam int IAD_PTR_W = 16;
	localparam int IAD_DADDR_W = 12;
	localparam int IAD_PADDR_W = 15;
	localparam int IAD_PWORD_W = 14;
	localparam int IAD_DATA_W = 8;
	localparam int IAD_BANK_W = 5;
	localparam int IAD_OFS_W = 7;
	localparam int IAD_PROG_BIT = 15;
	localparam logic [15:0] IAD_TRAD_LAST = 16'h0fff;
	localparam logic [15:0] IAD_LIN_BASE = 16'h2000;
	localparam logic [15:0] IAD_LIN_LAST = 16'h29af;
	localparam logic [11:0] IAD_LIN_BANK_BYTES = 12'h050;
	localparam logic [6:0] IAD_BANK_RAM_START = 7'h20;
	localparam logic [6:0] IAD_BANK_RAM_LAST = 7'h6f;
	localparam logic [6:0] IAD_WIN_OFS0 = 7'h00;
	localparam logic [6:0] IAD_WIN_OFS1 = 7'h01;
	localparam logic [7:0] IAD_RD_ZERO = 8'h00;
	// clock edges from request to done
	localparam int IAD_LAT_DATA = 3;
	localparam int IAD_LAT_PROG = 4;

	typedef enum logic [1:0] {
		IAD_RG_DATA,
		IAD_RG_LIN,
		IAD_RG_PROG,
		IAD_RG_NONE
	} iad_region_t;

	typedef enum logic [1:0] {
		IAD_ST_IDLE,
		IAD_ST_ISSUE,
		IAD_ST_CAPT,
		IAD_ST_EXTRA
	} iad_state_t;
endpackage

// ============================================================
// linear mapper
module iad_linear_map
	import iad_pkg::*;
(
	// linear pointer
	input wire logic [IAD_PTR_W-1:0] i_ptr,
	// absolute data address
	output logic [IAD_DADDR_W-1:0] o_addr
);
	logic [IAD_DADDR_W-1:0] lin_ofs;
	logic [IAD_DADDR_W-1:0] bank_q;
	logic [IAD_DADDR_W-1:0] bank_r;

	always_comb
	begin
		lin_ofs = i_ptr[IAD_DADDR_W-1:0] - IAD_LIN_BASE[IAD_DADDR_W-1:0];
		bank_q = lin_ofs / IAD_LIN_BANK_BYTES;
		bank_r = lin_ofs % IAD_LIN_BANK_BYTES;
		// remainder below 80 keeps clear of the common bytes at the bank top
		o_addr = {bank_q[IAD_BANK_W-1:0],
			IAD_BANK_RAM_START + bank_r[IAD_OFS_W-1:0]};
	end
endmodule

`default_nettype wire
